// ---- dv/windowed_watchdog_timer_test.sv ----
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
  localparam logic [7:0] CF = wwdt_pkg::CFG_ADDR;
  localparam logic [7:0] CT = wwdt_pkg::CTRL_ADDR;
  localparam logic [7:0] ST = wwdt_pkg::STAT_ADDR;
  localparam logic [7:0] CN = wwdt_pkg::CNT_ADDR;
  localparam logic [1:0] OK = wwdt_pkg::RESP_OKAY;
  localparam logic [1:0] SE = wwdt_pkg::RESP_SLVERR;
  // Bench side of every port
  logic aclk, aresetn, awv, wv, bry, arv, rry, low_power_rc_osc, secondary_osc, tick, csw, wake;
  logic [3:0] ws, wmask;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata;
  logic awr, wrd, bv, arr, rv, rst_req, wk, slp, idl, lpe, soe;
  logic [1:0] bresp, rresp;
  // Expected results, oldest first
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic exp_ev[$];
  int error_cnt, tests_run, seed;
  logic [9:0] cfv[4] = '{10'h2e0, 10'h2e1, 10'h2f0, 10'h2f3};
  int per[4] = '{32, 64, 128, 1024};

  wwdt_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .low_power_rc_osc_clk_pin(low_power_rc_osc), .secondary_osc_clk_pin(secondary_osc), .sys_timer_tick(tick),
    .clk_switch_done(csw), .wake_event(wake),
    .device_reset_req(rst_req), .wake_pulse(wk), .sleep_mode(slp), .idle_mode(idl),
    .low_power_rc_osc_osc_en(lpe), .secondary_osc_osc_en(soe)
  );

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    conclude();
  endtask

  // Take the oldest note whenever a result appears
  always @(posedge aclk) begin : watch
    logic e;
    if (rv && rry) begin
      if (exp_r.size() == 0) check(1'b1, 1'b0);
      else check({rresp, rdata}, exp_r.pop_front());
    end
    if (bv && bry) begin
      if (exp_b.size() == 0) check(1'b1, 1'b0);
      else check(bresp, exp_b.pop_front());
    end
    if (rst_req || wk) begin
      if (exp_ev.size() == 0) check(1'b1, 1'b0);
      else begin
        e = exp_ev.pop_front();
        check({rst_req, wk}, {~e, e});
      end
    end
  end

  // Write with both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic done;
    exp_b.push_back(r);
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    ws <= wmask;
    {awv, wv, bry} <= 3'h7;
    while (!done) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) begin
        bry <= 1'b0;
        done = 1'b1;
      end
      n++;
      if (n > 100) hang();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic done;
    exp_r.push_back({r, d});
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    ara <= a;
    {arv, rry} <= 2'h3;
    while (!done) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rry <= 1'b0;
        done = 1'b1;
      end
      n++;
      if (n > 100) hang();
    end
  endtask

  // Timer ticks, one per cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      tick <= 1'b1;
    end
    @(posedge aclk);
    tick <= 1'b0;
  endtask

  // Oscillator pin edges: low-power one, or secondary one when s is set
  task automatic lp(input int n, input logic s);
    repeat (n) begin
      repeat (3) @(posedge aclk);
      {secondary_osc, low_power_rc_osc} <= s ? 2'h2 : 2'h1;
      repeat (3) @(posedge aclk);
      {secondary_osc, low_power_rc_osc} <= 2'h0;
    end
  endtask

  task automatic pls(input logic w);
    @(posedge aclk);
    if (w) wake <= 1'b1;
    else csw <= 1'b1;
    @(posedge aclk);
    {wake, csw} <= 2'h0;
  endtask

  // Wait until every expected pulse has been seen
  task automatic drain();
    int n;
    n = 0;
    repeat (20) @(posedge aclk);
    while (exp_ev.size() != 0 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 200) hang();
  endtask

  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  initial begin
    logic [31:0] d;
    {awv, wv, bry, arv, rry, low_power_rc_osc, secondary_osc, tick, csw, wake} = '0;
    ws = 4'hf;
    wmask = 4'hf;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    aresetn = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    seed = 32'hb3402e72;
    rst();
    // Reset state and unmapped place
    rd(CF, 32'h0ff, OK);
    rd(CT, 32'h0, OK);
    rd(ST, 32'h8, OK);
    rd(CN, 32'h0, OK);
    rd(8'h10, 32'h0, SE);
    wr(8'h10, 32'h1, SE);
    @(negedge aclk);
    check(lpe, 1'b1);
    repeat (4) begin
      d = $random(seed) & 32'h39f;
      wr(CF, d, OK);
      rd(CF, d, OK);
    end
    wr(CF, 32'h1e0, OK);
    @(negedge aclk);
    check(soe, 1'b1);
    exp_ev.push_back(1'b0);
    lp(32, 1'b1);
    drain();
    // Time-out at every chosen period
    foreach (cfv[i]) begin
      wr(CF, {22'h0, cfv[i]}, OK);
      wr(CT, 32'h2, OK);
      ticks(per[i] - 1);
      rd(CN, per[i] - 1, OK);
      exp_ev.push_back(1'b0);
      ticks(1);
      drain();
    end
    wr(CT, 32'h2, OK);
    rd(ST, 32'h9, OK);
    wr(ST, 32'h1, OK);
    rd(ST, 32'h8, OK);
    ticks(10);
    wr(CT, 32'h2, OK);
    rd(CN, 32'h0, OK);
    // Clear without the low byte lane enabled is ignored
    ticks(10);
    wmask = 4'he;
    wr(CT, 32'h2, OK);
    wmask = 4'hf;
    rd(CN, 32'ha, OK);
    // Windowed mode: early clear, then a clear inside the window
    wr(CF, 32'h260, OK);
    ticks(10);
    exp_ev.push_back(1'b0);
    wr(CT, 32'h2, OK);
    drain();
    pls(1'b0);
    rd(CN, 32'h0, OK);
    wr(ST, 32'h1, OK);
    ticks(23);
    rd(ST, 32'h8, OK);
    ticks(1);
    rd(ST, 32'h18, OK);
    wr(CT, 32'h2, OK);
    rd(CN, 32'h0, OK);
    drain();
    // Sleep: timer ticks ignored, low-power edges wake
    wr(CF, 32'h2e0, OK);
    ticks(5);
    wr(CT, 32'h4, OK);
    rd(CN, 32'h0, OK);
    ticks(40);
    rd(CN, 32'h0, OK);
    @(negedge aclk);
    check({slp, lpe}, 2'h3);
    exp_ev.push_back(1'b1);
    lp(32, 1'b0);
    drain();
    @(negedge aclk);
    check(slp, 1'b0);
    rd(ST, 32'hd, OK);
    rd(CN, 32'h0, OK);
    // Idle keeps counting, other wake source leaves it
    wr(ST, 32'h7, OK);
    wr(CT, 32'h8, OK);
    ticks(5);
    rd(CN, 32'h5, OK);
    @(negedge aclk);
    check(idl, 1'b1);
    pls(1'b1);
    rd(CN, 32'h0, OK);
    rd(ST, 32'ha, OK);
    @(negedge aclk);
    check(idl, 1'b0);
    // Software-controlled mode
    wr(ST, 32'h7, OK);
    wr(CF, 32'h2c0, OK);
    rd(ST, 32'h0, OK);
    wr(CT, 32'h3, OK);
    rd(CT, 32'h1, OK);
    rd(ST, 32'h8, OK);
    exp_ev.push_back(1'b0);
    ticks(32);
    drain();
    rst();
    rd(CT, 32'h0, OK);
    rd(ST, 32'h8, OK);
    // Always-off mode
    wr(CF, 32'h280, OK);
    ticks(40);
    rd(ST, 32'h0, OK);
    drain();
    check(exp_r.size() + exp_b.size() + exp_ev.size(), 0);
    conclude();
  end

  // Cut a hang short
  initial begin
    repeat (60000) @(posedge aclk);
    hang();
  end
endmodule

// ---- hw/wwdt_pkg.sv ----
package wwdt_pkg;
  // Register byte addresses
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h04;
  localparam logic [7:0] STAT_ADDR = 8'h08;
  localparam logic [7:0] CNT_ADDR = 8'h0c;

  // Configuration word fields
  localparam int CFG_W = 10;
  localparam int CFG_PS_LSB = 0;
  localparam int CFG_PSA_BIT = 4;
  localparam int CFG_EN_LSB = 5;
  localparam int CFG_WINDOW_DISABLE_CFG_BIT = 7;
  localparam int CFG_SRC_LSB = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h0ff;

  // Control and status bits
  localparam int CTRL_SWEN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_IDLE_BIT = 3;
  localparam int STAT_TO_BIT = 0;
  localparam int STAT_IDLE_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_EN_BIT = 3;
  localparam int STAT_WIN_BIT = 4;

  // Enable modes and clock sources
  localparam logic [1:0] EN_ALWAYS = 2'h3;
  localparam logic [1:0] EN_SOFT = 2'h2;
  localparam logic [1:0] EN_OFF = 2'h0;
  localparam logic [1:0] SRC_LOW_POWER_RC_OSC = 2'h0;
  localparam logic [1:0] SRC_SECONDARY_OSC = 2'h1;
  localparam logic [1:0] SRC_SYST = 2'h2;

  // Prescaler shifts: 32 and 128 source edges per base period
  localparam logic [4:0] PRE_SHIFT_SHORT = 5'h05;
  localparam logic [4:0] PRE_SHIFT_LONG = 5'h07;
  localparam int CNT_W = 23;

  // Nominal timing of the low-power oscillator path
  localparam int LOW_POWER_RC_OSC_NOMINAL_HZ = 31000;
  localparam int SHORT_PERIOD_MS = 1;
  localparam int LONG_PERIOD_MS = 4;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE} wwdt_pwr_type;
endpackage

// ---- hw/wwdt_tick_src.sv ----
`timescale 1ns/1ps
module wwdt_tick_src (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Source clocks
  input wire logic low_power_rc_osc_clk_pin,
  input wire logic secondary_osc_clk_pin,
  input wire logic sys_timer_tick,
  // Selection
  input wire logic [1:0] src_sel,
  input wire logic force_low_power_rc_osc,
  // One-cycle count enable
  output logic tick
);
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] prev;
  logic [1:0] next_sync1;
  logic [1:0] next_sync2;
  logic [1:0] next_prev;
  logic [1:0] rise;
  logic [1:0] eff_sel;
  logic next_tick;

  // Edge pick from the effective source; sleep forces the low-power one
  always_comb begin
    next_sync1 = {secondary_osc_clk_pin, low_power_rc_osc_clk_pin};
    next_sync2 = sync1;
    next_prev = sync2;
    rise = sync2 & ~prev;
    eff_sel = force_low_power_rc_osc ? wwdt_pkg::SRC_LOW_POWER_RC_OSC : src_sel;
    case (eff_sel)
      wwdt_pkg::SRC_LOW_POWER_RC_OSC: next_tick = rise[0];
      wwdt_pkg::SRC_SECONDARY_OSC: next_tick = rise[1];
      wwdt_pkg::SRC_SYST: next_tick = sys_timer_tick;
      default: next_tick = rise[0];
    endcase
  end

  // Two-stage synchronisers and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      prev <= 2'h0;
      tick <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
      tick <= next_tick;
    end
  end
endmodule

// ---- hw/wwdt_top.sv ----
`timescale 1ns/1ps
// Contract
// - Clock from low-power, secondary or timer; sleep low-power
// - Enabled watchdog also enables its clock source
// - Prescaler divides by 32 or 128
// - Base period nominally 1 ms or 4 ms
// - Postscaler ratios 1:1 up to 1:32768
// - Reset and clock switch clear all counts
// - Power-save entry clears all counts
// - Leaving sleep or idle clears all counts
// - Clear instruction resets counter and scalers
// - Time-out in sleep or idle wakes device
// - Sleep and idle flags stay until software clears
// - Time-out flag sticky until software clears
// - Windowed clear works only in last quarter
// - Early windowed clear causes watchdog reset
// - Window mode when window-disable bit is zero
// - Enable field: 11 on, 10 software, 00 off
// - Software enable starts watchdog; reset clears it
module wwdt_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock sources and system events
  input wire logic low_power_rc_osc_clk_pin,
  input wire logic secondary_osc_clk_pin,
  input wire logic sys_timer_tick,
  input wire logic clk_switch_done,
  input wire logic wake_event,
  // Device side
  output logic device_reset_req,
  output logic wake_pulse,
  output logic sleep_mode,
  output logic idle_mode,
  output logic low_power_rc_osc_osc_en,
  output logic secondary_osc_osc_en
);
  localparam int CW = wwdt_pkg::CNT_W;

  // Terminal count of the whole period for given scaler settings
  function automatic logic [CW-1:0] last_count(logic [3:0] ps, logic psa);
    logic [4:0] sh;
    sh = psa ? wwdt_pkg::PRE_SHIFT_LONG : wwdt_pkg::PRE_SHIFT_SHORT;
    sh = sh + {1'b0, ps};
    return (CW'(1) << sh) - CW'(1);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // State
  logic [wwdt_pkg::CFG_W-1:0] cfg, next_cfg;
  logic swen, next_swen;
  logic to_flag, next_to_flag;
  logic sleep_flag, next_sleep_flag;
  logic idle_flag, next_idle_flag;
  wwdt_pkg::wwdt_pwr_type pwr, next_pwr;
  logic [CW-1:0] count, next_count;
  logic next_reset_req, next_wake, next_low_power_rc_osc_en, next_secondary_osc_en;
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic tick;

  // Decoded conditions
  logic enabled, windowed, in_window, timeout, asleep;
  logic do_write, wr_ctrl, wr_stat, clr_cmd, sleep_cmd, idle_cmd, violation;
  logic [CW-1:0] last;
  logic [31:0] stat_word, cfg_word;

  wwdt_tick_src u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .low_power_rc_osc_clk_pin(low_power_rc_osc_clk_pin),
    .secondary_osc_clk_pin(secondary_osc_clk_pin),
    .sys_timer_tick(sys_timer_tick),
    .src_sel(cfg[wwdt_pkg::CFG_SRC_LSB +: 2]),
    .force_low_power_rc_osc(pwr == wwdt_pkg::PWR_SLEEP),
    .tick(tick)
  );

  // Watchdog mode, window and command decode
  always_comb begin
    case (cfg[wwdt_pkg::CFG_EN_LSB +: 2])
      wwdt_pkg::EN_ALWAYS: enabled = 1'b1;
      wwdt_pkg::EN_SOFT: enabled = swen;
      default: enabled = 1'b0;
    endcase
    windowed = !cfg[wwdt_pkg::CFG_WINDOW_DISABLE_CFG_BIT];
    last = last_count(cfg[wwdt_pkg::CFG_PS_LSB +: 4], cfg[wwdt_pkg::CFG_PSA_BIT]);
    in_window = count >= (last - (last >> 2));
    asleep = pwr != wwdt_pkg::PWR_RUN;
    timeout = enabled && tick && (count == last);
    do_write = aw_hold && w_hold && !s_axi_bvalid;
    wr_ctrl = do_write && awaddr_q == wwdt_pkg::CTRL_ADDR && wstrb_q[0];
    wr_stat = do_write && awaddr_q == wwdt_pkg::STAT_ADDR && wstrb_q[0];
    clr_cmd = wr_ctrl && wdata_q[wwdt_pkg::CTRL_CLR_BIT] && !asleep;
    sleep_cmd = wr_ctrl && wdata_q[wwdt_pkg::CTRL_SLEEP_BIT] && !asleep;
    idle_cmd = wr_ctrl && wdata_q[wwdt_pkg::CTRL_IDLE_BIT] && !asleep && !sleep_cmd;
    violation = clr_cmd && enabled && windowed && !in_window;
  end

  // Counter, power state, flags and device-side outputs
  always_comb begin
    next_count = count;
    next_pwr = pwr;
    next_reset_req = 1'b0;
    next_wake = 1'b0;
    next_swen = swen;
    next_to_flag = to_flag;
    next_sleep_flag = sleep_flag;
    next_idle_flag = idle_flag;
    if (wr_ctrl) begin
      next_swen = wdata_q[wwdt_pkg::CTRL_SWEN_BIT];
    end
    // Software write-one clears; hardware sets below take priority
    if (wr_stat && wdata_q[wwdt_pkg::STAT_TO_BIT]) begin
      next_to_flag = 1'b0;
    end
    if (wr_stat && wdata_q[wwdt_pkg::STAT_IDLE_BIT]) begin
      next_idle_flag = 1'b0;
    end
    if (wr_stat && wdata_q[wwdt_pkg::STAT_SLEEP_BIT]) begin
      next_sleep_flag = 1'b0;
    end
    if (!enabled) begin
      next_count = '0;
    end else if (tick) begin
      next_count = count + CW'(1);
    end
    if (clk_switch_done) begin
      next_count = '0;
    end
    if (asleep) begin
      if (timeout) begin
        next_wake = 1'b1;
        next_to_flag = 1'b1;
        next_pwr = wwdt_pkg::PWR_RUN;
        next_count = '0;
      end else if (wake_event) begin
        next_pwr = wwdt_pkg::PWR_RUN;
        next_count = '0;
      end
    end else if (timeout || violation) begin
      next_reset_req = 1'b1;
      next_to_flag = 1'b1;
      next_count = '0;
    end else if (clr_cmd) begin
      next_count = '0;
    end else if (sleep_cmd || idle_cmd) begin
      next_count = '0;
      next_pwr = sleep_cmd ? wwdt_pkg::PWR_SLEEP : wwdt_pkg::PWR_IDLE;
      next_sleep_flag = next_sleep_flag | sleep_cmd;
      next_idle_flag = next_idle_flag | idle_cmd;
    end
    next_low_power_rc_osc_en = enabled && (next_pwr == wwdt_pkg::PWR_SLEEP
                   || cfg[wwdt_pkg::CFG_SRC_LSB +: 2] == wwdt_pkg::SRC_LOW_POWER_RC_OSC);
    next_secondary_osc_en = enabled && next_pwr != wwdt_pkg::PWR_SLEEP
                   && cfg[wwdt_pkg::CFG_SRC_LSB +: 2] == wwdt_pkg::SRC_SECONDARY_OSC;
  end

  // AXI4-Lite slave: capture, write, respond, read
  always_comb begin
    cfg_word = {{(32 - wwdt_pkg::CFG_W){1'b0}}, cfg};
    stat_word = '0;
    stat_word[wwdt_pkg::STAT_TO_BIT] = to_flag;
    stat_word[wwdt_pkg::STAT_IDLE_BIT] = idle_flag;
    stat_word[wwdt_pkg::STAT_SLEEP_BIT] = sleep_flag;
    stat_word[wwdt_pkg::STAT_EN_BIT] = enabled;
    stat_word[wwdt_pkg::STAT_WIN_BIT] = in_window;
    next_aw_hold = aw_hold;
    next_awaddr_q = awaddr_q;
    next_w_hold = w_hold;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_cfg = cfg;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wwdt_pkg::RESP_OKAY;
      case (awaddr_q)
        wwdt_pkg::CFG_ADDR: next_cfg = wwdt_pkg::CFG_W'(merge(cfg_word, wdata_q, wstrb_q));
        wwdt_pkg::CTRL_ADDR, wwdt_pkg::STAT_ADDR, wwdt_pkg::CNT_ADDR: next_bresp = wwdt_pkg::RESP_OKAY;
        default: next_bresp = wwdt_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = wwdt_pkg::RESP_OKAY;
      case (s_axi_araddr)
        wwdt_pkg::CFG_ADDR: next_rdata = cfg_word;
        wwdt_pkg::CTRL_ADDR: next_rdata = {31'h0, swen};
        wwdt_pkg::STAT_ADDR: next_rdata = stat_word;
        wwdt_pkg::CNT_ADDR: next_rdata = {{(32 - CW){1'b0}}, count};
        default: begin
          next_rdata = 32'h0;
          next_rresp = wwdt_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Register all state; device reset clears counts and software enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= wwdt_pkg::CFG_RESET;
      swen <= 1'b0;
      to_flag <= 1'b0;
      sleep_flag <= 1'b0;
      idle_flag <= 1'b0;
      pwr <= wwdt_pkg::PWR_RUN;
      count <= '0;
      device_reset_req <= 1'b0;
      wake_pulse <= 1'b0;
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
      low_power_rc_osc_osc_en <= 1'b0;
      secondary_osc_osc_en <= 1'b0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      cfg <= next_cfg;
      swen <= next_swen;
      to_flag <= next_to_flag;
      sleep_flag <= next_sleep_flag;
      idle_flag <= next_idle_flag;
      pwr <= next_pwr;
      count <= next_count;
      device_reset_req <= next_reset_req;
      wake_pulse <= next_wake;
      sleep_mode <= next_pwr == wwdt_pkg::PWR_SLEEP;
      idle_mode <= next_pwr == wwdt_pkg::PWR_IDLE;
      low_power_rc_osc_osc_en <= next_low_power_rc_osc_en;
      secondary_osc_osc_en <= next_secondary_osc_en;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      s_axi_awready <= !next_aw_hold && !next_bvalid;
      s_axi_wready <= !next_w_hold && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Checks on the watchdog behaviour
  a_timeout_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout |=> to_flag) else $error("time-out did not set flag");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    to_flag && !wr_stat ##1 !wr_stat |-> to_flag) else $error("time-out flag dropped");
  a_run_reset_req: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && !asleep |=> device_reset_req && !wake_pulse) else $error("no reset request");
  a_sleep_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && asleep |=> wake_pulse && !device_reset_req && !sleep_mode && !idle_mode)
    else $error("no wake on sleep time-out");
  a_early_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    violation |=> device_reset_req && count == '0) else $error("early clear not punished");
  a_window_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_cmd && in_window && !timeout && !clk_switch_done |=> count == '0 && !device_reset_req)
    else $error("window clear failed");
  a_entry_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_cmd && !timeout && !violation && !clr_cmd |=> count == '0 && sleep_flag && sleep_mode)
    else $error("power-save entry wrong");
  a_switch_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_switch_done |=> count == '0) else $error("clock switch did not clear");
  a_off_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg[wwdt_pkg::CFG_EN_LSB +: 2] == wwdt_pkg::EN_OFF)[*2] |-> count == '0 && !low_power_rc_osc_osc_en)
    else $error("disabled watchdog counting");
  a_swen_reset: assert property (@(posedge aclk)
    !aresetn |=> !swen) else $error("software enable survived reset");
  a_sleep_low_power_rc_osc: assert property (@(posedge aclk) disable iff (!aresetn)
    enabled && pwr == wwdt_pkg::PWR_SLEEP && $stable(cfg) |-> low_power_rc_osc_osc_en && !secondary_osc_osc_en)
    else $error("sleep not on low-power source");
  c_run_timeout: cover property (@(posedge aclk) disable iff (!aresetn) timeout && !asleep);
  c_sleep_wake: cover property (@(posedge aclk) disable iff (!aresetn) timeout && asleep);
  c_violation: cover property (@(posedge aclk) disable iff (!aresetn) violation);
  c_good_clear: cover property (@(posedge aclk) disable iff (!aresetn) clr_cmd && in_window);
endmodule
